// ==== core/rsi_device.sv ====
// receiver end: serial control slave, scheduler, packet path, transparent outputs, alert
`timescale 1ns/1ps
`include "rsi_consts.svh"
module rsi_device (
  input wire logic ref_clk,
  input wire logic rst_n,
  rsi_link_if.device_mp link,
  input wire logic in_chip, // demodulated chip from the front end
  input wire logic in_chip_en, // one-cycle pulse per chip
  input wire logic mf_bit, // matched filter sign output
  input wire logic slicer_bit, // raw slicer output
  input wire logic rssi_ok, // signal strength inside window
  input wire logic sig_recog, // signal recognised
  output logic rx_active // receive phase running
);
  import rsi_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // mode, polling and wake criterion form a legal set
  function automatic logic cfg_valid(input logic [7:0] c0, input logic [7:0] c1);
    logic [2:0] m;
    logic [1:0] p;
    logic [2:0] w;
    m = c0[2:0];
    p = c0[`RSI_POLL_LSB +: 2];
    w = c1[2:0];
    cfg_valid = 1'b0;
    if (m > 3'(raw_slicer_output_mode) || w > 3'(wake_pattern)) begin
      cfg_valid = 1'b0;
    end else if (m <= 3'(rsi_payload_mode)) begin
      cfg_valid = 1'b1;
    end else if (m == 3'(chip_data_strobe_mode)) begin
      cfg_valid = (w <= 3'(wake_sync));
    end else begin
      cfg_valid = (p == 2'(const_on_off_polling)) && (w == 3'(wake_rssi));
    end
  endfunction

  // wake criterion check on the chip history, or on the rssi and signal recognition inputs
  function automatic logic wake_met(input logic [2:0] w, input logic [7:0] ch, input logic [7:0] pat,
    input logic rs, input logic sr);
    wake_met = 1'b0;
    unique case (rsi_wuc_type'(w))
      wake_rssi: wake_met = rs;
      wake_sig_recog: wake_met = sr;
      wake_sync: wake_met = (ch == 8'h55) || (ch == 8'haa);
      wake_random: wake_met = (ch != 8'h00) && (ch != 8'hff);
      wake_equal: wake_met = (ch == 8'h00) || (ch == 8'hff);
      wake_pattern: wake_met = (ch == pat);
      default: wake_met = 1'b0;
    endcase
  endfunction

  rsi_dev_state_type st_reg; // all state
  rsi_dev_state_type st_next; // next state

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic rise, fall, tick, valid, met, pop, push, bitv, dec, abort;
    logic [4:0] ev, clr;
    logic [7:0] rdw, wd, byte_v;
    logic [6:0] wa;
    logic [7:0][7:0] cur;
    st_next = st_reg;
    ev = '0;
    clr = '0;
    pop = 1'b0;
    push = 1'b0;
    bitv = 1'b0;
    dec = 1'b0;
    abort = 1'b0;
    rdw = '0;
    byte_v = '0;
    // two-stage synchronisers on the link pins
    st_next.sclk_s1 = link.spi_sclk;
    st_next.sclk_s2 = st_reg.sclk_s1;
    st_next.sclk_s3 = st_reg.sclk_s2;
    st_next.cs_s1 = link.spi_cs_n;
    st_next.cs_s2 = st_reg.cs_s1;
    st_next.mosi_s1 = link.spi_mosi;
    st_next.mosi_s2 = st_reg.mosi_s1;
    rise = st_reg.sclk_s2 & ~st_reg.sclk_s3;
    fall = ~st_reg.sclk_s2 & st_reg.sclk_s3;
    wa = st_reg.spi_in[13:7];
    wd = {st_reg.spi_in[6:0], st_reg.mosi_s2};

    // ----------------------------------------
    // serial control slave
    // ----------------------------------------
    if (st_reg.cs_s2) begin // frame idle
      st_next.spi_cnt = '0;
      st_next.miso = 1'b0;
    end else if (rise) begin // sample on rising edge
      st_next.spi_in = {st_reg.spi_in[14:0], st_reg.mosi_s2};
      st_next.spi_cnt = st_reg.spi_cnt + 5'd1;
      if (st_reg.spi_cnt == 5'(`RSI_FRAME_BITS - 1) && st_reg.spi_in[14]) begin // write commit
        if (wa[6:5] == `RSI_SET_REGION) begin
          st_next.cfg[wa[4:3]][wa[2:0]] = wd;
        end else begin
          unique case (wa)
            `RSI_CTRL: st_next.ctrl = wd;
            `RSI_ALERT_CFG: st_next.alert_cfg = wd;
            `RSI_STATUS: clr = wd[4:0];
            `RSI_OFF_TIME: st_next.off_time = wd;
            default: ;
          endcase
        end
      end
    end else if (fall) begin // answer only inside a read frame
      if (st_reg.spi_cnt == 5'd8 && !st_reg.spi_in[7]) begin
        if (st_reg.spi_in[6:5] == `RSI_SET_REGION) begin
          rdw = st_reg.cfg[st_reg.spi_in[4:3]][st_reg.spi_in[2:0]];
        end else begin
          unique case (st_reg.spi_in[6:0])
            `RSI_CTRL: rdw = st_reg.ctrl;
            `RSI_ALERT_CFG: rdw = st_reg.alert_cfg;
            `RSI_STATUS: rdw = {3'b000, st_reg.status};
            `RSI_FIFO_DATA: begin
              rdw = (st_reg.level != 6'd0) ? st_reg.fifo[st_reg.rp] : 8'h00;
              pop = (st_reg.level != 6'd0);
            end
            `RSI_FIFO_LEVEL: rdw = {2'b00, st_reg.level};
            `RSI_OFF_TIME: rdw = st_reg.off_time;
            default: rdw = 8'h00;
          endcase
        end
        st_next.miso = rdw[7];
        st_next.spi_out = {rdw[6:0], 1'b0};
      end else if (st_reg.spi_cnt > 5'd8) begin
        st_next.miso = st_reg.spi_out[7];
        st_next.spi_out = {st_reg.spi_out[6:0], 1'b0};
      end
    end

    // ----------------------------------------
    // scheduler over the configuration sets
    // ----------------------------------------
    tick = (st_reg.tick_cnt == 6'(`RSI_TICK_CYC - 1));
    st_next.tick_cnt = tick ? 6'd0 : st_reg.tick_cnt + 6'd1;
    if (in_chip_en) begin
      st_next.chips = {st_reg.chips[6:0], in_chip};
    end
    cur = st_reg.cfg[st_reg.set];
    valid = cur[`RSI_K_MODE][`RSI_CFG_EN] && cfg_valid(cur[`RSI_K_MODE], cur[`RSI_K_WUC]);
    met = valid && wake_met(cur[`RSI_K_WUC][2:0], st_reg.chips, cur[`RSI_K_WPAT], rssi_ok, sig_recog);
    unique case (st_reg.sch)
      sch_off: begin // power-saving phase
        st_next.set = 2'd0;
        if (!st_reg.ctrl[`RSI_CTRL_RXEN]) begin
          st_next.time_cnt = '0;
        end else if (tick) begin
          if (st_reg.time_cnt >= st_reg.off_time) begin
            st_next.sch = sch_on;
            st_next.time_cnt = '0;
          end else begin
            st_next.time_cnt = st_reg.time_cnt + 8'd1;
          end
        end
      end
      sch_on: begin // listen with the current set
        if (!st_reg.ctrl[`RSI_CTRL_RXEN]) begin
          st_next.sch = sch_off;
        end else if (met) begin // wake-up recognised
          ev[`RSI_EV_WAKE] = 1'b1;
          st_next.sch = sch_run;
          st_next.pk = pk_hunt;
          st_next.half = 1'b0;
          st_next.time_cnt = '0;
        end else if (!valid || (tick && st_reg.time_cnt >= cur[`RSI_K_ON])) begin // next set
          st_next.time_cnt = '0;
          st_next.set = st_reg.set + 2'd1;
          if (st_reg.set == 2'd3) begin
            st_next.sch = sch_off;
          end
        end else if (tick) begin
          st_next.time_cnt = st_reg.time_cnt + 8'd1;
        end
      end
      sch_run: begin // receive phase
        if (tick && st_reg.pk == pk_hunt) begin
          st_next.time_cnt = st_reg.time_cnt + 8'd1;
        end
        if (!st_reg.ctrl[`RSI_CTRL_RXEN] || (tick && st_reg.pk == pk_hunt
            && st_reg.time_cnt >= cur[`RSI_K_ON])) begin // timed reception window
          abort = 1'b1;
        end
      end
      default: st_next.sch = sch_off;
    endcase

    // ----------------------------------------
    // packet path: line decoding and deframing
    // ----------------------------------------
    if (st_reg.sch == sch_run && cur[`RSI_K_MODE][2:0] <= 3'(rsi_payload_mode) && in_chip_en) begin
      st_next.half = ~st_reg.half;
      if (st_reg.half) begin // chip pair: 10 is one, 01 is zero
        if (st_reg.chips[0] != in_chip) begin
          bitv = 1'b1;
          dec = st_reg.chips[0];
        end else if (st_reg.pk == pk_hunt) begin
          st_next.half = 1'b1; // slip one chip to realign
        end else begin
          abort = 1'b1; // code violation ends the telegram
        end
      end
    end
    if (bitv) begin
      st_next.bits = {st_reg.bits[6:0], dec};
      if (st_reg.pk == pk_hunt) begin
        if ({st_reg.bits[6:0], dec} == cur[`RSI_K_TSI]) begin // start identifier found
          ev[`RSI_EV_TSI] = 1'b1;
          st_next.pk = pk_payload;
          st_next.bit_cnt = '0;
          st_next.byte_cnt = '0;
        end
      end else begin
        st_next.bit_cnt = st_reg.bit_cnt + 3'd1;
        if (cur[`RSI_K_MODE][2:0] == 3'(rsi_payload_mode)) begin // serial copy of fifo data
          st_next.data_out = dec;
          st_next.strobe_cnt = 3'(`RSI_STROBE_CYC);
        end
        if (st_reg.bit_cnt == 3'd7) begin
          byte_v = {st_reg.bits[6:0], dec};
          push = 1'b1;
          if (st_reg.byte_cnt == 8'd0 && cur[`RSI_K_WUC][`RSI_MSGID_EN]
              && byte_v == cur[`RSI_K_MSGID]) begin
            ev[`RSI_EV_MSGID] = 1'b1;
          end
          st_next.byte_cnt = st_reg.byte_cnt + 8'd1;
          if (st_reg.byte_cnt + 8'd1 >= cur[`RSI_K_LEN]) begin
            ev[`RSI_EV_EOM] = 1'b1;
            abort = 1'b1;
          end
        end
      end
    end
    if (abort) begin
      st_next.sch = sch_off;
      st_next.time_cnt = '0;
    end

    // ----------------------------------------
    // receive fifo
    // ----------------------------------------
    if (push && st_reg.level == 6'(`RSI_FIFO_WORDS) && !pop) begin
      ev[`RSI_EV_OVF] = 1'b1; // full: byte dropped
      push = 1'b0;
    end
    if (push) begin
      st_next.fifo[st_reg.wp] = byte_v;
      st_next.wp = st_reg.wp + 5'd1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 5'd1;
    end
    st_next.level = st_reg.level + 6'(push) - 6'(pop);

    // ----------------------------------------
    // transparent outputs
    // ----------------------------------------
    if (st_reg.strobe_cnt != 3'd0) begin
      st_next.strobe_cnt = st_reg.strobe_cnt - 3'd1;
    end
    if (st_reg.sch != sch_run) begin
      st_next.data_out = 1'b0;
    end else begin
      unique case (cur[`RSI_K_MODE][2:0])
        3'(chip_data_strobe_mode): begin
          if (in_chip_en) begin
            st_next.data_out = in_chip;
            st_next.strobe_cnt = 3'(`RSI_STROBE_CYC);
          end
        end
        3'(matched_filter_output_mode): st_next.data_out = mf_bit;
        3'(raw_slicer_output_mode): st_next.data_out = slicer_bit;
        default: ;
      endcase
    end

    // ----------------------------------------
    // events and alert pin
    // ----------------------------------------
    st_next.status = (st_reg.status & ~clr) | ev; // a new event wins over the clear
    st_next.alert = (|(st_next.status & st_reg.alert_cfg[4:0])) ^ st_reg.alert_cfg[`RSI_ALERT_POL];
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // pins from flip-flops; rx_strobe and rx_active decoded from registered state
  assign link.spi_miso = st_reg.miso;
  assign link.alert = st_reg.alert;
  assign link.rx_data = st_reg.data_out;
  assign link.rx_strobe = (st_reg.strobe_cnt != 3'd0) ^ st_reg.ctrl[`RSI_CTRL_SPOL];
  assign rx_active = (st_reg.sch == sch_run);
endmodule

// ==== core/rsi_consts.svh ====
// offsets, field positions, reset values and timing counts of the receiver system interface
`ifndef RSI_CONSTS_SVH
`define RSI_CONSTS_SVH
// ----------------------------------------
// device registers, reached over the serial control link
// ----------------------------------------
`define RSI_CTRL 7'h00
`define RSI_ALERT_CFG 7'h01
`define RSI_STATUS 7'h02
`define RSI_FIFO_DATA 7'h03
`define RSI_FIFO_LEVEL 7'h04
`define RSI_OFF_TIME 7'h05
`define RSI_SET_REGION 2'b01
`define RSI_CTRL_RST 8'h00
`define RSI_ALERT_CFG_RST 8'h00
// ----------------------------------------
// fields
// ----------------------------------------
`define RSI_CTRL_RXEN 0
`define RSI_CTRL_SPOL 1
`define RSI_ALERT_POL 7
`define RSI_EV_WAKE 0
`define RSI_EV_TSI 1
`define RSI_EV_MSGID 2
`define RSI_EV_EOM 3
`define RSI_EV_OVF 4
`define RSI_K_MODE 3'd0
`define RSI_K_WUC 3'd1
`define RSI_K_WPAT 3'd2
`define RSI_K_TSI 3'd3
`define RSI_K_MSGID 3'd4
`define RSI_K_ON 3'd5
`define RSI_K_LEN 3'd6
`define RSI_CFG_EN 7
`define RSI_POLL_LSB 3
`define RSI_MSGID_EN 7
`define RSI_FIFO_WORDS 32
`define RSI_FRAME_BITS 16
// ----------------------------------------
// controller registers on the plain port
// ----------------------------------------
`define RSI_H_CMD 3'h0
`define RSI_H_RDATA 3'h1
`define RSI_H_IRQ_STAT 3'h2
`define RSI_H_IRQ_MASK 3'h3
`define RSI_H_CFG 3'h4
`define RSI_H_DATA 3'h5
`define RSI_H_BUSY 8
`define RSI_HEV_DONE 0
`define RSI_HEV_ALERT 1
`define RSI_HEV_BYTE 2
// ----------------------------------------
// timing
// ----------------------------------------
`define RSI_CLK_NS 25
`define RSI_SCLK_NS 200
`define RSI_SCLK_HALF_CYC (`RSI_SCLK_NS / (2 * `RSI_CLK_NS))
`define RSI_TICK_NS 1000
`define RSI_TICK_CYC ((`RSI_TICK_NS + `RSI_CLK_NS - 1) / `RSI_CLK_NS)
`define RSI_STROBE_NS 100
`define RSI_STROBE_CYC ((`RSI_STROBE_NS + `RSI_CLK_NS - 1) / `RSI_CLK_NS)
`endif

// ==== core/rsi_pkg.sv ====
// types of the receiver system interface
package rsi_pkg;
  // receive modes
  typedef enum logic [2:0] {rsi_fifo_mode, rsi_payload_mode, chip_data_strobe_mode,
    matched_filter_output_mode, raw_slicer_output_mode} rsi_mode_type;
  // polling schemes
  typedef enum logic [1:0] {const_on_off_polling, fast_fallback_polling, mixed_polling,
    pulsed_wakeup_polling} rsi_poll_type;
  // wake-up criteria
  typedef enum logic [2:0] {wake_rssi, wake_sig_recog, wake_sync, wake_random, wake_equal,
    wake_pattern} rsi_wuc_type;
  typedef enum logic [1:0] {sch_off, sch_on, sch_run} rsi_sched_type;
  typedef enum logic {pk_hunt, pk_payload} rsi_pkt_type;
  typedef enum logic [1:0] {h_idle, h_shift, h_tail} rsi_host_phase_type;
  // whole device state
  typedef struct packed {
    logic sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, mosi_s1, mosi_s2;
    logic [4:0] spi_cnt;
    logic [15:0] spi_in;
    logic [7:0] spi_out;
    logic miso;
    logic [7:0] ctrl, alert_cfg, off_time;
    logic [4:0] status;
    logic [3:0][7:0][7:0] cfg;
    rsi_sched_type sch;
    logic [1:0] set;
    logic [5:0] tick_cnt;
    logic [7:0] time_cnt;
    rsi_pkt_type pk;
    logic [7:0] chips, bits, byte_cnt;
    logic half;
    logic [2:0] bit_cnt;
    logic [31:0][7:0] fifo;
    logic [4:0] wp, rp;
    logic [5:0] level;
    logic data_out, alert;
    logic [2:0] strobe_cnt;
  } rsi_dev_state_type;
  // whole controller state
  typedef struct packed {
    logic alert_s1, alert_s2, miso_s1, miso_s2, data_s1, data_s2, strb_s1, strb_s2, strb_s3;
    rsi_host_phase_type ph;
    logic [1:0] div_cnt;
    logic [4:0] bit_cnt;
    logic sclk, cs_act, mosi;
    logic [15:0] sh_out, sh_in, rd_q;
    logic [7:0] rdata, rx_byte;
    logic [2:0] rx_bits, irq_stat, irq_mask;
    logic [1:0] cfg;
  } rsi_host_state_type;
endpackage

// ==== core/rsi_link_if.sv ====
// pins between receiver and application controller
`timescale 1ns/1ps
interface rsi_link_if;
  logic spi_sclk; // serial clock, made by the controller
  logic spi_cs_n; // frame select, active low
  logic spi_mosi; // controller to receiver
  logic spi_miso; // receiver to controller
  logic alert; // alert pin, polarity configurable
  logic rx_data; // transparent data output
  logic rx_strobe; // strobe or chip clock estimate
  modport device_mp(input spi_sclk, spi_cs_n, spi_mosi, output spi_miso, alert, rx_data, rx_strobe);
  modport host_mp(output spi_sclk, spi_cs_n, spi_mosi, input spi_miso, alert, rx_data, rx_strobe);
endinterface

// ==== core/rsi_host.sv ====
// controller end: serial master, alert and data capture, register port with interrupt
`timescale 1ns/1ps
`include "rsi_consts.svh"
module rsi_host (
  input wire logic ref_clk,
  input wire logic rst_n,
  rsi_link_if.host_mp link,
  input wire logic [2:0] reg_addr, // register index
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, cycle after the strobe
  output logic irq // level interrupt
);
  import rsi_pkg::*;

  rsi_host_state_type st_reg; // all state
  rsi_host_state_type st_next; // next state

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic half, strb_edge;
    logic [2:0] ev, clr;
    st_next = st_reg;
    ev = '0;
    clr = '0;
    // synchronisers on pins from the receiver
    st_next.alert_s1 = link.alert;
    st_next.alert_s2 = st_reg.alert_s1;
    st_next.miso_s1 = link.spi_miso;
    st_next.miso_s2 = st_reg.miso_s1;
    st_next.data_s1 = link.rx_data;
    st_next.data_s2 = st_reg.data_s1;
    st_next.strb_s1 = link.rx_strobe;
    st_next.strb_s2 = st_reg.strb_s1;
    st_next.strb_s3 = st_reg.strb_s2;
    half = (st_reg.div_cnt == 2'(`RSI_SCLK_HALF_CYC - 1));
    st_next.div_cnt = half ? 2'd0 : st_reg.div_cnt + 2'd1;
    // ----------------------------------------
    // serial master, clock made by division
    // ----------------------------------------
    unique case (st_reg.ph)
      h_idle: begin
        if (reg_wr && reg_addr == `RSI_H_CMD) begin // start a frame
          st_next.ph = h_shift;
          st_next.cs_act = 1'b1;
          st_next.sh_out = reg_wdata;
          st_next.mosi = reg_wdata[15];
          st_next.div_cnt = '0;
          st_next.bit_cnt = '0;
        end
      end
      h_shift: begin
        if (half && !st_reg.sclk) begin
          st_next.sclk = 1'b1;
        end else if (half) begin // falling edge: sample, then next bit
          st_next.sclk = 1'b0;
          st_next.sh_in = {st_reg.sh_in[14:0], st_reg.miso_s2};
          st_next.sh_out = {st_reg.sh_out[14:0], 1'b0};
          st_next.mosi = st_reg.sh_out[14];
          st_next.bit_cnt = st_reg.bit_cnt + 5'd1;
          if (st_reg.bit_cnt == 5'(`RSI_FRAME_BITS - 1)) begin
            st_next.rdata = {st_reg.sh_in[6:0], st_reg.miso_s2};
            st_next.ph = h_tail;
          end
        end
      end
      h_tail: begin
        if (half) begin
          st_next.cs_act = 1'b0;
          st_next.mosi = 1'b0;
          st_next.ph = h_idle;
          ev[`RSI_HEV_DONE] = 1'b1;
        end
      end
      default: st_next.ph = h_idle;
    endcase
    // ----------------------------------------
    // alert and transparent data capture
    // ----------------------------------------
    ev[`RSI_HEV_ALERT] = st_reg.alert_s2 ^ st_reg.cfg[0];
    strb_edge = (st_reg.strb_s2 ^ st_reg.cfg[1]) & ~(st_reg.strb_s3 ^ st_reg.cfg[1]);
    if (strb_edge) begin
      st_next.rx_byte = {st_reg.rx_byte[6:0], st_reg.data_s2};
      st_next.rx_bits = st_reg.rx_bits + 3'd1;
      ev[`RSI_HEV_BYTE] = (st_reg.rx_bits == 3'd7);
    end
    // ----------------------------------------
    // register port
    // ----------------------------------------
    if (reg_wr) begin
      unique case (reg_addr)
        `RSI_H_IRQ_STAT: clr = reg_wdata[2:0];
        `RSI_H_IRQ_MASK: st_next.irq_mask = reg_wdata[2:0];
        `RSI_H_CFG: begin
          st_next.cfg = reg_wdata[1:0];
          st_next.rx_bits = '0;
        end
        default: ;
      endcase
    end
    st_next.rd_q = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `RSI_H_RDATA: st_next.rd_q = {7'd0, st_reg.ph != h_idle, st_reg.rdata};
        `RSI_H_IRQ_STAT: st_next.rd_q = {13'd0, st_reg.irq_stat};
        `RSI_H_IRQ_MASK: st_next.rd_q = {13'd0, st_reg.irq_mask};
        `RSI_H_CFG: st_next.rd_q = {14'd0, st_reg.cfg};
        `RSI_H_DATA: st_next.rd_q = {8'd0, st_reg.rx_byte};
        default: st_next.rd_q = '0;
      endcase
    end
    st_next.irq_stat = (st_reg.irq_stat & ~clr) | ev; // set wins over clear
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.spi_sclk = st_reg.sclk;
  assign link.spi_cs_n = ~st_reg.cs_act;
  assign link.spi_mosi = st_reg.mosi;
  assign reg_rdata = st_reg.rd_q;
  assign irq = |(st_reg.irq_stat & st_reg.irq_mask);
endmodule

// ==== dv/rsi_link_checker.sv ====
// link checker for the receiver system interface
`timescale 1ns/1ps
module rsi_link_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic spi_miso,
  input wire logic alert,
  input wire logic rx_data,
  input wire logic rx_strobe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] rise_reg; // sclk rises in this frame
  logic sclk_reg; // sclk one cycle back
  // counts rises, cleared between frames
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_reg <= 5'h00;
      sclk_reg <= 1'b0;
    end else begin
      sclk_reg <= spi_sclk;
      rise_reg <= spi_cs_n ? 5'h00 : rise_reg + 5'(spi_sclk & ~sclk_reg);
    end
  end
  property p_idle; spi_cs_n |-> !spi_sclk; endproperty
  a_idle: assert property (p_idle) else $error("sclk outside frame");
  property p_high; $rose(spi_sclk) |-> spi_sclk [*4] ##1 !spi_sclk; endproperty
  a_high: assert property (p_high) else $error("sclk high width");
  property p_lead; $fell(spi_cs_n) |-> ##4 $rose(spi_sclk); endproperty
  a_lead: assert property (p_lead) else $error("first rise late");
  property p_tail; $rose(spi_cs_n) |-> !$past(spi_sclk, 4); endproperty
  a_tail: assert property (p_tail) else $error("frame end early");
  property p_count; $rose(spi_cs_n) |-> rise_reg == 5'd16; endproperty
  a_count: assert property (p_count) else $error("frame not 16 bits");
  property p_mosi; spi_sclk |-> $stable(spi_mosi); endproperty
  a_mosi: assert property (p_mosi) else $error("mosi moved");
  property p_miso; spi_sclk && $past(spi_sclk) |-> $stable(spi_miso); endproperty
  a_miso: assert property (p_miso) else $error("miso moved");
  property p_quiet; spi_cs_n [*8] |-> !spi_miso; endproperty
  a_quiet: assert property (p_quiet) else $error("miso outside frame");
  c_frame: cover property ($rose(spi_cs_n));
  c_alert: cover property ($rose(alert));
  c_data: cover property ($rose(rx_data));
endmodule

// ==== dv/rsi_tb_top.sv ====
// bench joining both ends over the link
`timescale 1ns/1ps
module rsi_tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic irq;
  logic mf_bit = 1'b0;
  logic rssi_ok = 1'b0;
  logic in_chip = 1'b0; // chip from the front end
  logic in_chip_en = 1'b0; // one pulse per chip
  logic rx_active;
  logic [15:0] q; // last read word
  logic [7:0] bad_k0 [3] = '{8'h8c, 8'h83, 8'h82}; // mode/polling of the unsupported pairings
  logic [7:0] bad_k1 [3] = '{8'h00, 8'h01, 8'h05}; // paired wake criteria
  int fail_count = 0;
  int comparisons = 0;
  int n;
  rsi_link_if link();
  always #12.5 ref_clk = ~ref_clk;
  rsi_device rsi_device_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .in_chip(in_chip),
    .in_chip_en(in_chip_en), .mf_bit(mf_bit), .slicer_bit(1'b0), .rssi_ok(rssi_ok), .sig_recog(1'b0),
    .rx_active(rx_active));
  rsi_host rsi_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  rsi_link_checker rsi_link_checker_inst (.ref_clk(ref_clk), .rst_n(rst_n), .spi_sclk(link.spi_sclk),
    .spi_cs_n(link.spi_cs_n), .spi_mosi(link.spi_mosi), .spi_miso(link.spi_miso), .alert(link.alert),
    .rx_data(link.rx_data), .rx_strobe(link.rx_strobe));
  task automatic summarize();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge ref_clk);
  endtask
  // one framed device access, waits while busy
  task automatic dev(input logic w, input logic [6:0] a, input logic [7:0] d);
    int k = 0;
    wr(3'h0, {w, a, d});
    do begin
      rd(3'h1, q);
      k++;
    end while (q[8] !== 1'b0 && k < 300);
    chk(16'(q[8]), 16'h0000);
  endtask
  // one byte as chip pairs, first chip carries the bit, one chip every 8 cycles
  task automatic send(input logic [7:0] b);
    for (int j = 15; j >= 0; j--) begin
      in_chip <= b[j / 2] ~^ j[0];
      in_chip_en <= 1'b1;
      @(posedge ref_clk);
      in_chip_en <= 1'b0;
      repeat (7) @(posedge ref_clk);
    end
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(3'h1, q);
    chk(q, 16'h0000);
    wr(3'h3, 16'h0001);
    dev(1'b1, 7'h01, 8'h1f);
    #1 chk(16'(irq), 16'h0001);
    wr(3'h2, 16'h0001);
    #1 chk(16'(irq), 16'h0000);
    wr(3'h3, 16'h0000);
    dev(1'b0, 7'h01, 8'h00);
    chk(q, 16'h001f);
    rd(3'h2, q);
    chk(q, 16'h0001);
    dev(1'b0, 7'h7f, 8'h00);
    chk(q, 16'h0000);
    dev(1'b0, 7'h02, 8'h00);
    chk(q, 16'h0000);
    dev(1'b0, 7'h04, 8'h00);
    chk(q, 16'h0000);
    wr(3'h2, 16'h0007);
    wr(3'h4, 16'h0001);
    dev(1'b1, 7'h01, 8'h80);
    #1 chk(16'(link.alert), 16'h0001);
    wr(3'h2, 16'h0002);
    rd(3'h2, q);
    chk(q, 16'h0001);
    dev(1'b1, 7'h01, 8'h01);
    wr(3'h4, 16'h0000);
    dev(1'b1, 7'h05, 8'h00);
    dev(1'b1, 7'h21, 8'h00);
    dev(1'b1, 7'h25, 8'h08);
    dev(1'b1, 7'h20, 8'h83);
    rssi_ok <= 1'b1;
    mf_bit <= 1'b1;
    dev(1'b1, 7'h00, 8'h01);
    n = 0;
    while (rx_active !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(16'(rx_active), 16'h0001);
    repeat (4) @(posedge ref_clk);
    #1 chk(16'(link.rx_data), 16'h0001);
    chk(16'(link.alert), 16'h0001);
    @(posedge ref_clk);
    mf_bit <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 chk(16'(link.rx_data), 16'h0000);
    dev(1'b1, 7'h00, 8'h00);
    mf_bit <= 1'b1;
    // unsupported pairings never open a receive phase
    foreach (bad_k0[i]) begin
      dev(1'b1, 7'h21, bad_k1[i]);
      dev(1'b1, 7'h20, bad_k0[i]);
      dev(1'b1, 7'h00, 8'h01);
      n = 0;
      repeat (600) begin
        @(posedge ref_clk);
        #1 n += int'((rx_active | link.rx_data) !== 1'b0);
      end
      chk(16'(n), 16'h0000);
    end
    // payload mode: start id, message id, two bytes into the fifo and onto the strobed line
    dev(1'b1, 7'h00, 8'h00);
    dev(1'b1, 7'h21, 8'h80);
    dev(1'b1, 7'h23, 8'hb4);
    dev(1'b1, 7'h24, 8'h5a);
    dev(1'b1, 7'h26, 8'h02);
    dev(1'b1, 7'h20, 8'h81);
    wr(3'h4, 16'h0000);
    dev(1'b1, 7'h00, 8'h01);
    n = 0;
    while (rx_active !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    send(8'hb4);
    send(8'h5a);
    send(8'hc3);
    dev(1'b1, 7'h00, 8'h00);
    dev(1'b0, 7'h04, 8'h00);
    chk(q, 16'h0002);
    dev(1'b0, 7'h03, 8'h00);
    chk(q, 16'h005a);
    dev(1'b0, 7'h03, 8'h00);
    chk(q, 16'h00c3);
    dev(1'b0, 7'h02, 8'h00);
    chk(q, 16'h000f);
    rd(3'h5, q);
    chk(q, 16'h00c3);
    wr(3'h3, 16'h0004);
    #1 chk(16'(irq), 16'h0001);
    summarize();
  end
endmodule
